//--- rtl/mmpd_cfg.svh
`ifndef MMPD_CFG_SVH
`define MMPD_CFG_SVH

// register indices; byte address is four times the index
`define MMPD_IDX_RAM_POS     6'h10
`define MMPD_IDX_SIZE0       6'h1C
`define MMPD_IDX_SIZE1       6'h1D
`define MMPD_IDX_PAGE        6'h30

`define MMPD_RAM_POS_RST     8'h09
`define MMPD_RAM_POS_WMASK   8'hF9
`define MMPD_RAM_POS_MSB     7
`define MMPD_RAM_POS_LSB     3
`define MMPD_RAM_HAL_BIT     0

// integration choice: 0 = open page register, 1 = special modes only
`define MMPD_PAGE_RESTRICT   1'b0
`define MMPD_PAGE_RST_OPEN   6'h00
`define MMPD_PAGE_RST_LOCK   6'h3C

`define MMPD_SIZE1_FLASH_MSB 7
`define MMPD_SIZE1_FLASH_LSB 6
`define MMPD_SIZE1_PAG_MSB   1
`define MMPD_SIZE1_PAG_LSB   0
`define MMPD_SIZE0_REG_BIT   7
`define MMPD_SIZE0_EEP_MSB   5
`define MMPD_SIZE0_EEP_LSB   4
`define MMPD_SIZE0_RAM_MSB   2
`define MMPD_SIZE0_RAM_LSB   0

`define MMPD_REG_BASE        16'h0000
`define MMPD_REG_SIZE_1K     16'h0400
`define MMPD_REG_SIZE_2K     16'h0800
`define MMPD_PORTAB_SIZE     16'h0004
`define MMPD_EBI_REG_SIZE    16'h0010
`define MMPD_EE_BASE         16'h0000

`define MMPD_WIN_PREFIX      2'b10
`define MMPD_LOW_PREFIX      2'b01
`define MMPD_HIGH_PREFIX     2'b11
`define MMPD_PIX_INT_00      6'h38
`define MMPD_PIX_INT_01      6'h30
`define MMPD_PIX_INT_10      6'h20
`define MMPD_PIX_INT_11      6'h00

`endif

//--- rtl/mmpd_pkg.sv
`default_nettype none
package mmpd_pkg;

    typedef enum logic [2:0]
    {
        mmpd_special_single,
        mmpd_special_expanded,
        mmpd_special_periph,
        mmpd_emul_narrow,
        mmpd_emul_wide,
        mmpd_normal_single,
        mmpd_normal_exp_narrow,
        mmpd_normal_exp_wide
    } mmpd_mode_type;

    typedef struct packed {
        logic [2:0] ram_space_switch;
        logic [1:0] eep_space_switch;
        logic       reg_space_switch;
        logic [1:0] flash_space_switch;
        logic [1:0] paging_partition_switch;
    } mmpd_switch_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        valid;
        logic        write;
        logic        swap;
        logic        bdm;
    } mmpd_cpu_type;

    typedef struct packed {
        logic [15:0] bdm;
        logic [15:0] regs;
        logic [15:0] ram;
        logic [15:0] eeprom;
        logic [15:0] flash;
        logic [15:0] ext;
    } mmpd_src_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        valid;
        logic        write;
    } mmpd_core_type;

    typedef struct packed {
        logic bdm;
        logic regs;
        logic ram;
        logic eeprom;
        logic flash;
        logic ext;
    } mmpd_sel_type;

    typedef struct packed {
        logic [5:0]    page;
        logic          pend_v;
        logic [5:0]    pend;
        logic [7:0]    ram_pos;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        mmpd_core_type core;
        mmpd_sel_type  sel;
        logic          swap;
        logic [15:0]   rdata;
        logic          ecs_n;
        logic          xcs_n;
        logic          pk_cs;
    } mmpd_state_type;

endpackage : mmpd_pkg
`default_nettype wire

//--- rtl/mmpd_ram_window.sv
`include "mmpd_cfg.svh"
`default_nettype none
module mmpd_ram_window
(
    input  wire logic [15:0] addr_in,
    input  wire logic [2:0]  ram_space_switch_in,
    input  wire logic [7:0]  ram_pos_in,
    output logic             hit_out
);
    import mmpd_pkg::*;

    logic [15:0] ram_size;
    logic [15:0] region_size;
    logic [15:0] region_mask;
    logic [15:0] region_base;
    logic [15:0] ram_off;
    logic [15:0] ram_lo;
    logic        high_align;

    always_comb
    begin
        // allocation grows in 2k steps, one per code
        ram_size = {1'b0, {1'b0, ram_space_switch_in} + 4'h1, 11'h000};
        unique case (ram_space_switch_in)
            3'b000: region_size = 16'h0800;
            3'b001: region_size = 16'h1000;
            3'b010: region_size = 16'h2000;
            3'b011: region_size = 16'h2000;
            3'b100: region_size = 16'h4000;
            3'b101: region_size = 16'h4000;
            3'b110: region_size = 16'h4000;
            3'b111: region_size = 16'h4000;
        endcase
        region_mask = ~(region_size - 16'h0001);
        region_base = {ram_pos_in[`MMPD_RAM_POS_MSB:`MMPD_RAM_POS_LSB],
                       11'h000} & region_mask;
        high_align = ram_pos_in[`MMPD_RAM_HAL_BIT];
        ram_off = addr_in & ~region_mask;
        ram_lo = high_align ? region_size - ram_size : 16'h0000;
        hit_out = ((addr_in & region_mask) == region_base)
                  && (ram_off >= ram_lo)
                  && (ram_off < ram_lo + ram_size);
    end

endmodule : mmpd_ram_window
`default_nettype wire

//--- rtl/mmpd_top.sv
`include "mmpd_cfg.svh"
`default_nettype none
// Summary of operation
// - ram base after reset follows the position register reset value.
// - high-align bit places the allocation at the top of its region.
// - size view at index 1D is read-only and mirrors integration switches.
// - size view bits 7:6 show the flash space switch.
// - size view bits 1:0 show the paging partition switch.
// - six page bits map a 16k page into window 8000..BFFF.
// - page bits decode directly as page number 0..63.
// - page reset and write policy fixed at integration: 00 open or 3C locked.
// - a bus write to the page register takes effect one cycle later.
// - call and return instructions have a private page read/write path.
// - private page update completes before the instruction ends.
// - read data muxed to cpu; cpu address and write data steered out.
// - cpu read data is byte swapped when the access asks for it.
// - an address selects core, register, memory or external space, or nothing outside expanded modes.
// - mode and mapping registers steer the selects.
// - two active-low chip selects go out: emulation and external.
// - one select at most, by priority debug, regs, ram, eeprom, flash, ext.
// - emulation select low on flash space in emulation mode with port k set.
// - external select low only for external space, never removed registers.
// - window internal or external from paging switch and page number.
module mmpd_top
(
    input  wire logic                    sys_clk_in,
    input  wire logic                    rstn_in,
    input  wire logic                    ce_in,
    input  wire logic [7:0]              paddr_in,
    input  wire logic                    psel_in,
    input  wire logic                    penable_in,
    input  wire logic                    pwrite_in,
    input  wire logic [31:0]             pwdata_in,
    output logic [31:0]                  prdata_out,
    output logic                         pready_out,
    output logic                         pslverr_out,
    input  wire mmpd_pkg::mmpd_mode_type mode_in,
    input  wire logic                    port_k_emulation_enable_in,
    input  wire mmpd_pkg::mmpd_switch_type sw_in,
    input  wire mmpd_pkg::mmpd_cpu_type  cpu_in,
    input  wire mmpd_pkg::mmpd_src_type  src_rdata_in,
    input  wire logic                    call_wr_in,
    input  wire logic [5:0]              call_page_in,
    output logic [5:0]                   page_index_bits_out,
    output mmpd_pkg::mmpd_core_type      core_bus_out,
    output mmpd_pkg::mmpd_sel_type       sel_out,
    output logic [15:0]                  cpu_rdata_out,
    output logic                         emulation_chip_select_n_out,
    output logic                         external_chip_select_n_out,
    output logic                         port_k_cs_mode_out
);
    import mmpd_pkg::*;

    mmpd_state_type s_q;
    mmpd_state_type s_d;
    mmpd_sel_type   dec_sel;
    logic           ram_hit;
    logic           reg_hit;
    logic           removed;
    logic           ee_hit;
    logic           flash_hit;
    logic           win_hit;
    logic           page_int;
    logic           expanded;
    logic           emulation;
    logic           special;
    logic           ecs_hit;
    logic           xcs_hit;
    logic [15:0]    reg_size;
    logic [15:0]    ee_size;
    logic [15:0]    reg_off;
    logic [5:0]     pix_first;
    logic           apb_done;
    logic           is_page;
    logic           is_size0;
    logic           is_size1;
    logic           is_ram_pos;
    logic           mapped;
    logic           page_wr_ok;
    logic [31:0]    rd_word;
    logic [15:0]    rd_raw;

    mmpd_ram_window u_ram_window
    (
        .addr_in             (cpu_in.addr),
        .ram_space_switch_in (sw_in.ram_space_switch),
        .ram_pos_in          (s_q.ram_pos),
        .hit_out             (ram_hit)
    );

    // mode classes
    always_comb
    begin
        special = (mode_in == mmpd_special_single)
                  || (mode_in == mmpd_special_expanded)
                  || (mode_in == mmpd_special_periph);
        emulation = (mode_in == mmpd_emul_narrow)
                    || (mode_in == mmpd_emul_wide);
        expanded = emulation
                   || (mode_in == mmpd_special_expanded)
                   || (mode_in == mmpd_normal_exp_narrow)
                   || (mode_in == mmpd_normal_exp_wide);
    end

    // address classification
    always_comb
    begin
        reg_size = sw_in.reg_space_switch ? `MMPD_REG_SIZE_2K
                                          : `MMPD_REG_SIZE_1K;
        reg_off = cpu_in.addr - `MMPD_REG_BASE;
        reg_hit = reg_off < reg_size;
        // bus expansion registers leave the map in these modes
        removed = (expanded && (reg_off < `MMPD_PORTAB_SIZE))
                  || ((mode_in == mmpd_special_periph)
                      && (reg_off < `MMPD_EBI_REG_SIZE));
        unique case (sw_in.eep_space_switch)
            2'b00: ee_size = 16'h0000;
            2'b01: ee_size = 16'h0800;
            2'b10: ee_size = 16'h1000;
            2'b11: ee_size = 16'h2000;
        endcase
        ee_hit = (cpu_in.addr - `MMPD_EE_BASE) < ee_size;
        unique case (sw_in.paging_partition_switch)
            2'b00: pix_first = `MMPD_PIX_INT_00;
            2'b01: pix_first = `MMPD_PIX_INT_01;
            2'b10: pix_first = `MMPD_PIX_INT_10;
            2'b11: pix_first = `MMPD_PIX_INT_11;
        endcase
        page_int = s_q.page >= pix_first;
        win_hit = cpu_in.addr[15:14] == `MMPD_WIN_PREFIX;
        // page number is used as is, no remap table
        flash_hit = (sw_in.flash_space_switch != 2'b00)
                    && ((cpu_in.addr[15:14] == `MMPD_HIGH_PREFIX)
                        || ((cpu_in.addr[15:14] == `MMPD_LOW_PREFIX)
                            && sw_in.flash_space_switch[1])
                        || (win_hit && page_int));
    end

    // priority select; later branches never see overlapped space
    always_comb
    begin
        dec_sel = '0;
        ecs_hit = 1'b0;
        xcs_hit = 1'b0;
        if (cpu_in.valid)
        begin
            if (cpu_in.bdm)
            begin
                dec_sel.bdm = 1'b1;
            end
            else if (reg_hit && !removed)
            begin
                dec_sel.regs = 1'b1;
            end
            else if (reg_hit)
            begin
                // removed registers go off chip without a chip select in expanded modes, else select nothing
                dec_sel.ext = expanded;
            end
            else if (ram_hit)
            begin
                dec_sel.ram = 1'b1;
            end
            else if (ee_hit)
            begin
                dec_sel.eeprom = 1'b1;
            end
            else if (flash_hit)
            begin
                dec_sel.flash = 1'b1;
                ecs_hit = emulation && port_k_emulation_enable_in;
            end
            else if (expanded)
            begin
                dec_sel.ext = 1'b1;
                xcs_hit = port_k_emulation_enable_in;
            end
        end
    end

    // register bus decode
    always_comb
    begin
        apb_done = psel_in && penable_in && s_q.pready;
        is_page = paddr_in == {`MMPD_IDX_PAGE, 2'b00};
        is_size0 = paddr_in == {`MMPD_IDX_SIZE0, 2'b00};
        is_size1 = paddr_in == {`MMPD_IDX_SIZE1, 2'b00};
        is_ram_pos = paddr_in == {`MMPD_IDX_RAM_POS, 2'b00};
        mapped = is_page || is_size0 || is_size1 || is_ram_pos;
        page_wr_ok = (`MMPD_PAGE_RESTRICT == 1'b0) || special;
        rd_word = 32'h0000_0000;
        if (is_page)
        begin
            rd_word[5:0] = s_q.page;
        end
        if (is_size1)
        begin
            rd_word[`MMPD_SIZE1_FLASH_MSB:`MMPD_SIZE1_FLASH_LSB] =
                sw_in.flash_space_switch;
            rd_word[`MMPD_SIZE1_PAG_MSB:`MMPD_SIZE1_PAG_LSB] =
                sw_in.paging_partition_switch;
        end
        if (is_size0)
        begin
            rd_word[`MMPD_SIZE0_REG_BIT] = sw_in.reg_space_switch;
            rd_word[`MMPD_SIZE0_EEP_MSB:`MMPD_SIZE0_EEP_LSB] =
                sw_in.eep_space_switch;
            rd_word[`MMPD_SIZE0_RAM_MSB:`MMPD_SIZE0_RAM_LSB] =
                sw_in.ram_space_switch;
        end
        if (is_ram_pos)
        begin
            rd_word[7:0] = s_q.ram_pos;
        end
    end

    // read data source follows the registered select
    always_comb
    begin
        rd_raw = 16'h0000;
        if (s_q.sel.bdm)
            rd_raw = src_rdata_in.bdm;
        if (s_q.sel.regs)
            rd_raw = src_rdata_in.regs;
        if (s_q.sel.ram)
            rd_raw = src_rdata_in.ram;
        if (s_q.sel.eeprom)
            rd_raw = src_rdata_in.eeprom;
        if (s_q.sel.flash)
            rd_raw = src_rdata_in.flash;
        if (s_q.sel.ext)
            rd_raw = src_rdata_in.ext;
    end

    always_comb
    begin
        s_d = s_q;
        if (psel_in && !penable_in)
        begin
            // zero wait states: answer is ready in the access phase
            s_d.pready = 1'b1;
            s_d.pslverr = !mapped;
            s_d.prdata = rd_word;
        end
        else if (apb_done)
        begin
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
        end
        if (s_q.pend_v)
        begin
            s_d.page = s_q.pend;
            s_d.pend_v = 1'b0;
        end
        if (apb_done && pwrite_in && is_page && page_wr_ok)
        begin
            s_d.pend_v = 1'b1;
            s_d.pend = pwdata_in[5:0];
        end
        if (apb_done && pwrite_in && is_ram_pos)
        begin
            s_d.ram_pos = pwdata_in[7:0] & `MMPD_RAM_POS_WMASK;
        end
        if (call_wr_in)
        begin
            // private path beats a stale bus write still in flight
            s_d.page = call_page_in;
            s_d.pend_v = 1'b0;
        end
        s_d.core.addr = cpu_in.addr;
        s_d.core.wdata = cpu_in.wdata;
        s_d.core.valid = cpu_in.valid;
        s_d.core.write = cpu_in.write;
        s_d.sel = dec_sel;
        s_d.swap = cpu_in.swap;
        s_d.rdata = s_q.swap ? {rd_raw[7:0], rd_raw[15:8]}
                             : rd_raw;
        s_d.ecs_n = !ecs_hit;
        s_d.xcs_n = !xcs_hit;
        s_d.pk_cs = port_k_emulation_enable_in;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s_q <= '0;
            s_q.page <= (`MMPD_PAGE_RESTRICT != 1'b0) ? `MMPD_PAGE_RST_LOCK
                                                      : `MMPD_PAGE_RST_OPEN;
            s_q.ram_pos <= `MMPD_RAM_POS_RST;
            s_q.ecs_n <= 1'b1;
            s_q.xcs_n <= 1'b1;
        end
        else if (ce_in)
        begin
            s_q <= s_d;
        end
    end

    assign prdata_out = s_q.prdata;
    assign pready_out = s_q.pready;
    assign pslverr_out = s_q.pslverr;
    assign page_index_bits_out = s_q.page;
    assign core_bus_out = s_q.core;
    assign sel_out = s_q.sel;
    assign cpu_rdata_out = s_q.rdata;
    assign emulation_chip_select_n_out = s_q.ecs_n;
    assign external_chip_select_n_out = s_q.xcs_n;
    assign port_k_cs_mode_out = s_q.pk_cs;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_page_wr_delay: assert property (
        (ce_in && apb_done && pwrite_in && is_page && page_wr_ok
         && !call_wr_in) ##1 (ce_in && !call_wr_in)
        |=> (s_q.page == $past(pwdata_in[5:0], 2)))
        else $error("page write not applied one cycle later");

    a_page_locked: assert property (
        (ce_in && apb_done && pwrite_in && is_page && !page_wr_ok
         && !s_q.pend_v && !call_wr_in)
        |=> (!s_q.pend_v && $stable(s_q.page)))
        else $error("locked page register changed on bus write");

    a_page_hi_zero: assert property (
        (apb_done && !pwrite_in && is_page)
        |-> (prdata_out[31:6] == 26'h0000000))
        else $error("page register upper bits not zero");

    a_size_view: assert property (
        (apb_done && !pwrite_in && is_size1 && $stable(sw_in))
        |-> (prdata_out[7:0] == {sw_in.flash_space_switch, 4'h0,
                                 sw_in.paging_partition_switch}))
        else $error("size view does not mirror switches");

    a_call_page: assert property (
        (ce_in && call_wr_in)
        |=> (page_index_bits_out == $past(call_page_in)))
        else $error("call path page update late or lost");

    a_one_select: assert property (
        $onehot0(sel_out))
        else $error("more than one select active");

    a_cs_exclusive: assert property (
        !(!emulation_chip_select_n_out && !external_chip_select_n_out))
        else $error("both chip selects active");

    a_removed_no_xcs: assert property (
        (ce_in && cpu_in.valid && !cpu_in.bdm && reg_hit)
        |=> external_chip_select_n_out)
        else $error("external select on register space");

    a_ecs_flash: assert property (
        (ce_in && dec_sel.flash && emulation && port_k_emulation_enable_in)
        |=> !emulation_chip_select_n_out)
        else $error("emulation select missing on flash access");

    a_window_ext: assert property (
        (cpu_in.valid && win_hit && !page_int) |-> !dec_sel.flash)
        else $error("external page decoded as on-chip flash");

    a_byte_swap: assert property (
        (ce_in && s_q.swap && s_q.sel.ram)
        |=> (cpu_rdata_out == {$past(src_rdata_in.ram[7:0]),
                               $past(src_rdata_in.ram[15:8])}))
        else $error("read data not swapped");

endmodule : mmpd_top
`default_nettype wire

//--- testbench/mmpd_far_model.sv
`default_nettype none
module mmpd_far_model
#(
    parameter logic [95:0] DATA = 96'h0
)
(
    input  wire logic                   sys_clk_in,
    input  wire mmpd_pkg::mmpd_sel_type sel_in,
    output mmpd_pkg::mmpd_src_type      src_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import mmpd_pkg::*;

    logic [15:0] cnt_q = 16'h0;
    logic [5:0]  sel_v;
    logic [95:0] bus_v;

    assign sel_v = sel_in;

    always_ff @(posedge sys_clk_in)
        cnt_q <= cnt_q + 16'h1;

    // an unselected source never holds its last word, so a late
    // or early sample of the read mux shows up as a wrong value
    always_comb
    begin
        for (int i = 0; i < 6; i++)
            bus_v[16*i +: 16] = sel_v[i] ? DATA[16*i +: 16]
                                         : cnt_q + 16'(i);
    end

    assign src_out = bus_v;
endmodule : mmpd_far_model
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mmpd_pkg::*;

    localparam logic [95:0] SRC = 96'hB0B1_1E1F_2A2B_3C3D_4E4F_5A5B;

    logic            sys_clk_in  = 1'b0;
    logic            rstn_in     = 1'b0;
    logic [7:0]      paddr       = 8'h00;
    logic            psel        = 1'b0;
    logic            penable     = 1'b0;
    logic            pwrite      = 1'b0;
    logic [31:0]     pwdata      = 32'h0;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            pk          = 1'b1;
    logic            ce          = 1'b1;
    logic            pkm;
    logic            call_wr     = 1'b0;
    logic [5:0]      call_page   = 6'h00;
    logic [5:0]      page;
    mmpd_mode_type   mode        = mmpd_emul_wide;
    mmpd_switch_type sw          = 10'b100_00_0_11_00;
    mmpd_cpu_type    cpu         = '0;
    mmpd_src_type    src;
    mmpd_core_type   core;
    mmpd_sel_type    sel;
    logic [15:0]     rdata;
    logic            ecs_n;
    logic            xcs_n;
    int              n_mismatch  = 0;
    int              check_count = 0;

    initial
    begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    mmpd_top mmpd_top_inst (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ce_in(ce),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .mode_in(mode),
        .port_k_emulation_enable_in(pk), .sw_in(sw), .cpu_in(cpu),
        .src_rdata_in(src), .call_wr_in(call_wr),
        .call_page_in(call_page), .page_index_bits_out(page),
        .core_bus_out(core), .sel_out(sel), .cpu_rdata_out(rdata),
        .emulation_chip_select_n_out(ecs_n),
        .external_chip_select_n_out(xcs_n), .port_k_cs_mode_out(pkm));

    mmpd_far_model #(.DATA(SRC)) mmpd_far_model_inst (
        .sys_clk_in(sys_clk_in), .sel_in(sel), .src_out(src));

    task automatic test_done();
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int i;
        @(posedge sys_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        // outputs read right after the edge still hold their sampled value
        for (i = 0; i < 20; i++)
        begin
            @(posedge sys_clk_in);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_mismatch++;
            test_done();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cpu_chk(input logic [15:0] a, input logic b, s,
                           input logic [5:0] es, input logic [1:0] ec);
        logic [15:0] d;
        d = 16'h0;
        for (int i = 0; i < 6; i++)
            if (es[i])
                d = SRC[16*i +: 16];
        if (s)
            d = {d[7:0], d[15:8]};
        @(posedge sys_clk_in);
        cpu <= '{a, 16'h5A5A, 1'b1, 1'b0, s, b};
        @(posedge sys_clk_in);
        #1;
        chk("sel", {26'h0, es}, {26'h0, sel});
        chk("cs", {30'h0, ec}, {30'h0, ecs_n, xcs_n});
        chk("core addr", {16'h0, a}, {16'h0, core.addr});
        @(posedge sys_clk_in);
        #1;
        if (es != 6'h00)
            chk("rdata", {16'h0, d}, {16'h0, rdata});
    endtask : cpu_chk

    task automatic call_set(input logic [5:0] v);
        @(posedge sys_clk_in);
        call_wr <= 1'b1;
        call_page <= v;
        @(posedge sys_clk_in);
        call_wr <= 1'b0;
        #1;
        chk("call page", {26'h0, v}, {26'h0, page});
    endtask : call_set

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        apb(1'b0, 8'hC0, 32'h0, r, e);
        chk("page reset", 32'h0, r);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("ram pos reset", 32'h09, r);
        apb(1'b0, 8'h70, 32'h0, r, e);
        chk("size0 view", 32'h04, r);
        apb(1'b1, 8'h74, 32'hFF, r, e);
        apb(1'b0, 8'h74, 32'h0, r, e);
        chk("size1 view", 32'hC0, r);
        apb(1'b0, 8'h44, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask : t_regs

    task automatic t_page();
        logic [31:0] r;
        logic        e;
        apb(1'b1, 8'hC0, 32'hFF, r, e);
        #1;
        chk("page hold", 32'h0, {26'h0, page});
        @(posedge sys_clk_in);
        #1;
        chk("page new", 32'h3F, {26'h0, page});
        apb(1'b0, 8'hC0, 32'h0, r, e);
        chk("page upper", 32'h3F, r);
        apb(1'b1, 8'hC0, 32'h10, r, e);
    endtask : t_page

    // 10k of ram high-aligned in 0000..3FFF sits at 1800..3FFF
    task automatic t_decode();
        cpu_chk(16'h0010, 1'b0, 1'b0, 6'h10, 2'b11);
        cpu_chk(16'h0010, 1'b1, 1'b1, 6'h20, 2'b11);
        cpu_chk(16'h0002, 1'b0, 1'b0, 6'h01, 2'b11);
        cpu_chk(16'h1800, 1'b0, 1'b1, 6'h08, 2'b11);
        cpu_chk(16'h17FF, 1'b0, 1'b0, 6'h01, 2'b10);
        cpu_chk(16'h4000, 1'b0, 1'b0, 6'h02, 2'b01);
        cpu_chk(16'h8000, 1'b0, 1'b0, 6'h01, 2'b10);
        call_set(6'h37);
        cpu_chk(16'hBFFF, 1'b0, 1'b0, 6'h01, 2'b10);
        call_set(6'h38);
        cpu_chk(16'h8000, 1'b0, 1'b1, 6'h02, 2'b01);
    endtask : t_decode

    task automatic t_mode();
        @(posedge sys_clk_in);
        pk <= 1'b0;
        cpu_chk(16'h17FF, 1'b0, 1'b0, 6'h01, 2'b11);
        chk("pk mode", 32'h0, {31'h0, pkm});
        cpu_chk(16'h4000, 1'b0, 1'b0, 6'h02, 2'b11);
        @(posedge sys_clk_in);
        pk <= 1'b1;
        mode <= mmpd_normal_single;
        cpu_chk(16'h17FF, 1'b0, 1'b0, 6'h00, 2'b11);
        chk("pk mode", 32'h1, {31'h0, pkm});
        cpu_chk(16'h4000, 1'b0, 1'b0, 6'h02, 2'b11);
    endtask : t_mode

    // a frozen block must ignore a private page write
    task automatic t_ce();
        @(posedge sys_clk_in);
        ce <= 1'b0;
        call_wr <= 1'b1;
        call_page <= 6'h05;
        @(posedge sys_clk_in);
        call_wr <= 1'b0;
        ce <= 1'b1;
        #1;
        chk("ce hold", 32'h38, {26'h0, page});
    endtask : t_ce

    task automatic t_views();
        logic [31:0] r;
        logic        e;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge sys_clk_in);
            sw[3:0] <= {k[1:0], k[1:0]};
            apb(1'b0, 8'h74, 32'h0, r, e);
            chk("size1 code", {24'h0, k[1:0], 4'h0, k[1:0]}, r);
        end
        // ram moved to the top region, high aligned: D800..FFFF
        apb(1'b1, 8'h40, 32'hFF, r, e);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk("ram pos", 32'hF9, r);
        cpu_chk(16'hD800, 1'b0, 1'b0, 6'h08, 2'b11);
        cpu_chk(16'hC000, 1'b0, 1'b0, 6'h02, 2'b11);
    endtask : t_views

    initial
    begin
        repeat (10) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_regs();
        t_page();
        t_decode();
        t_mode();
        t_ce();
        t_views();
        test_done();
    end
endmodule : tb
`default_nettype wire
